// ### design/rtcha_top.v
// Real-time clock core with serial host link, interrupts and APB
`include "rtcha_consts.vh"
module rtcha_top #(
  parameter SEC_CYCLES = `RTCHA_SEC_CYCLES,
  parameter DIVW       = 27,
  parameter [7:0] MONTH_DAYS = `RTCHA_MONTH_DAYS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire        ce,
  input  wire        sclk,
  input  wire        sio_in,
  output reg         sio_out,
  output reg         sio_oe,
  input  wire        osc_halt,
  input  wire        backup_resume,
  output reg         interrupt_out_n,
  output reg         interrupt_oe
);
  localparam integer    TOP_I    = SEC_CYCLES - 1;
  localparam integer    HALF_I   = SEC_CYCLES / 2;
  localparam integer    QUAR_I   = SEC_CYCLES / 4;
  localparam [DIVW-1:0] DIV_TOP  = TOP_I[DIVW-1:0];
  localparam [DIVW-1:0] DIV_HALF = HALF_I[DIVW-1:0];
  localparam [DIVW-1:0] DIV_QUAR = QUAR_I[DIVW-1:0];

  wire [4:0] syn;
  rtcha_sync #(.WIDTH(5)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({backup_resume, osc_halt, sio_in, sclk, ce}),
    .q       (syn)
  );
  wire s_ce   = syn[0];
  wire s_sclk = syn[1];
  wire s_sio  = syn[2];
  wire s_halt = syn[3];
  wire s_bkup = syn[4];

  reg        sclk_d;
  reg        ce_d;
  reg  [4:0] bcnt;
  reg  [7:0] cmd;
  reg  [7:0] shr;
  reg  [7:0] sec, min, hour, wday, day, mon;
  reg  [7:0] aw_min, aw_hour, aw_days, ad_min, ad_hour;
  reg        wae, dae, osc_stop_flag, periodic_irq_flag, wafg, dafg;
  reg  [2:0] periodic_select;
  reg  [DIVW-1:0] div;
  reg        tick_d;
  reg  [2:0] strap_cnt;
  reg  [3:0] status;
  reg  [3:0] mask;
  reg        run;
  reg  [7:0] old;

  wire rise    = s_sclk & ~sclk_d;
  wire fall    = ~s_sclk & sclk_d;
  wire is_rd   = cmd[`RTCHA_CMD_RD];
  wire [3:0] nib = {shr[2:0], s_sio};
  wire wr_hi   = rise & s_ce & ~is_rd & (bcnt == `RTCHA_BIT_HI);
  wire wr_lo   = rise & s_ce & ~is_rd & (bcnt == `RTCHA_BIT_LO);
  wire wr      = wr_hi | wr_lo;
  wire [3:0] waddr = cmd[7:4];
  wire [7:0] newv  = wr_hi ? {nib, old[3:0]} : {old[7:4], nib};
  wire tick    = run & (div == DIV_TOP);
  wire sec_wr  = wr & (waddr == `RTCHA_S_SEC);
  wire abort   = ~s_ce & ce_d & (bcnt != 5'd0) & (bcnt < `RTCHA_BIT_END);

  // Serial register read view
  always @* begin
    case (waddr)
      `RTCHA_S_SEC:    old = sec;
      `RTCHA_S_MIN:    old = min;
      `RTCHA_S_HOUR:   old = hour;
      `RTCHA_S_WDAY:   old = wday;
      `RTCHA_S_DAY:    old = day;
      `RTCHA_S_MON:    old = mon;
      `RTCHA_S_AWMIN:  old = aw_min;
      `RTCHA_S_AWHOUR: old = aw_hour;
      `RTCHA_S_AWDAYS: old = aw_days;
      `RTCHA_S_ADMIN:  old = ad_min;
      `RTCHA_S_ADHOUR: old = ad_hour;
      `RTCHA_S_CTRL1:  old = {wae, dae, 1'b0, osc_stop_flag, 1'b0, periodic_select};
      `RTCHA_S_CTRL2:  old = {5'h00, periodic_irq_flag, wafg, dafg};
      default:         old = 8'h00;
    endcase
  end

  // Serial link: command byte, then data byte, MSB first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d  <= 1'b0;
      ce_d    <= 1'b0;
      bcnt    <= 5'd0;
      cmd     <= 8'h00;
      shr     <= 8'h00;
      sio_out <= 1'b0;
      sio_oe  <= 1'b0;
    end else begin
      sclk_d <= s_sclk;
      ce_d   <= s_ce;
      if (!s_ce) begin
        bcnt   <= 5'd0;
        sio_oe <= 1'b0;
      end else if (rise && bcnt < `RTCHA_BIT_END) begin
        bcnt <= bcnt + 5'd1;
        if (bcnt < 5'd8)
          cmd <= {cmd[6:0], s_sio};
        else if (!is_rd)
          shr <= {shr[6:0], s_sio};
      end else if (fall && is_rd && bcnt >= 5'd8) begin
        if (bcnt == 5'd8) begin
          sio_out <= old[7];
          shr     <= {old[6:0], 1'b0};
          sio_oe  <= 1'b1;
        end else if (bcnt == `RTCHA_BIT_END) begin
          sio_oe <= 1'b0;
        end else begin
          sio_out <= shr[7];
          shr     <= {shr[6:0], 1'b0};
        end
      end
    end
  end

  // Timebase and calendar
  wire [7:0] sec_n  = (sec == 8'd59) ? 8'd0 : sec + 8'd1;
  wire       min_c  = (sec == 8'd59);
  wire       hour_c = min_c & (min == 8'd59);
  wire       day_c  = hour_c & (hour == 8'd23);
  wire       mon_c  = day_c & (day == MONTH_DAYS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div     <= {DIVW{1'b0}};
      tick_d  <= 1'b0;
      sec     <= 8'h00;
      min     <= 8'h00;
      hour    <= 8'h00;
      wday    <= 8'h00;
      day     <= 8'h01;
      mon     <= 8'h01;
      aw_min  <= 8'h00;
      aw_hour <= 8'h00;
      aw_days <= 8'h00;
      ad_min  <= 8'h00;
      ad_hour <= 8'h00;
      wae     <= 1'b0;
      dae     <= 1'b0;
      periodic_select <= `RTCHA_PS_OFF;
    end else begin
      tick_d <= tick & ~sec_wr;
      if (sec_wr || tick || !run)
        div <= {DIVW{1'b0}};
      else
        div <= div + {{(DIVW-1){1'b0}}, 1'b1};
      if (tick && !sec_wr) begin
        sec <= sec_n;
        if (min_c)
          min <= (min == 8'd59) ? 8'd0 : min + 8'd1;
        if (hour_c)
          hour <= (hour == 8'd23) ? 8'd0 : hour + 8'd1;
        if (day_c) begin
          wday <= (wday == 8'd6) ? 8'd0 : wday + 8'd1;
          day  <= (day == MONTH_DAYS) ? 8'd1 : day + 8'd1;
        end
        if (mon_c)
          mon <= (mon == 8'd12) ? 8'd1 : mon + 8'd1;
      end
      if (wr) begin
        case (waddr)
          `RTCHA_S_SEC:    sec     <= newv;
          `RTCHA_S_MIN:    min     <= newv;
          `RTCHA_S_HOUR:   hour    <= newv;
          `RTCHA_S_WDAY:   wday    <= newv;
          `RTCHA_S_DAY:    day     <= newv;
          `RTCHA_S_MON:    mon     <= newv;
          `RTCHA_S_AWMIN:  aw_min  <= newv;
          `RTCHA_S_AWHOUR: aw_hour <= newv;
          `RTCHA_S_AWDAYS: aw_days <= newv;
          `RTCHA_S_ADMIN:  ad_min  <= newv;
          `RTCHA_S_ADHOUR: ad_hour <= newv;
          `RTCHA_S_CTRL1: begin
            wae <= newv[`RTCHA_C1_WAE];
            dae <= newv[`RTCHA_C1_DAE];
            periodic_select <= newv[2:0];
          end
          default: ;
        endcase
      end
    end
  end

  // Alarm and periodic events, evaluated the cycle after a second tick
  wire at_min0 = tick_d & (sec == 8'd0);
  wire w_match = at_min0 & wae & (min == aw_min) & (hour == aw_hour) & aw_days[wday[2:0]];
  wire d_match = at_min0 & dae & (min == ad_min) & (hour == ad_hour);
  reg  per_ev;
  always @* begin
    case (periodic_select)
      `RTCHA_PS_SEC:  per_ev = tick_d;
      `RTCHA_PS_MIN:  per_ev = at_min0;
      `RTCHA_PS_HOUR: per_ev = at_min0 & (min == 8'd0);
      `RTCHA_PS_MON:  per_ev = at_min0 & (min == 8'd0) & (hour == 8'd0) & (day == 8'd1);
      default:        per_ev = 1'b0;
    endcase
  end
  wire c2_clr = wr_lo & (waddr == `RTCHA_S_CTRL2);
  wire c1_hi  = wr_hi & (waddr == `RTCHA_S_CTRL1);
  wire halt_ev = s_halt & ~s_ce;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_irq_flag      <= 1'b0;
      wafg      <= 1'b0;
      dafg      <= 1'b0;
      osc_stop_flag      <= 1'b1;
      strap_cnt <= 3'd0;
    end else begin
      // Set wins over a same-cycle clear
      periodic_irq_flag <= per_ev | (periodic_irq_flag & ~(c2_clr & ~nib[`RTCHA_C2_PERIODIC_IRQ_FLAG]));
      wafg <= w_match | (wafg & ~(c2_clr & ~nib[`RTCHA_C2_WAFG]));
      dafg <= d_match | (dafg & ~(c2_clr & ~nib[`RTCHA_C2_DAFG]));
      // Strap read late enough for the synchroniser to have settled
      if (strap_cnt != 3'd7)
        strap_cnt <= strap_cnt + 3'd1;
      if (halt_ev)
        osc_stop_flag <= 1'b1;
      else if (strap_cnt == 3'd5 && s_bkup)
        osc_stop_flag <= 1'b0;
      else if (c1_hi && !nib[`RTCHA_C1_OSC_STOP_FLAG - 4])
        osc_stop_flag <= 1'b0;
    end
  end

  // Open-drain interrupt pin, pulled low while any source is active
  wire pulse_1hz = div < DIV_HALF;
  wire pulse_2hz = (div < DIV_QUAR) | ((div >= DIV_HALF) & (div < DIV_HALF + DIV_QUAR));
  reg  per_low;
  always @* begin
    case (periodic_select)
      `RTCHA_PS_LOW: per_low = 1'b1;
      `RTCHA_PS_2HZ: per_low = run & pulse_2hz;
      `RTCHA_PS_1HZ: per_low = run & pulse_1hz;
      `RTCHA_PS_OFF: per_low = 1'b0;
      default:       per_low = periodic_irq_flag;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_out_n <= 1'b0;
      interrupt_oe    <= 1'b0;
    end else begin
      interrupt_out_n <= 1'b0;
      interrupt_oe    <= wafg | dafg | per_low;
    end
  end

  // APB slave, one wait state
  wire apb_take = psel & penable & ~pready;
  wire apb_done = psel & penable & pready;
  wire a_stat   = (paddr == `RTCHA_A_STATUS);
  wire a_mask   = (paddr == `RTCHA_A_MASK);
  wire a_ctrl   = (paddr == `RTCHA_A_CTRL);
  wire a_state  = (paddr == `RTCHA_A_STATE);
  wire mapped   = a_stat | a_mask | a_ctrl | a_state;
  wire [3:0] ev;
  assign ev[`RTCHA_EV_TICK]  = tick;
  assign ev[`RTCHA_EV_PER]   = per_ev;
  assign ev[`RTCHA_EV_ALARM] = w_match | d_match;
  assign ev[`RTCHA_EV_ABORT] = abort;
  wire stat_clr = apb_done & ~pwrite & a_stat;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      status  <= 4'h0;
      mask    <= 4'h0;
      run     <= `RTCHA_CTRL_RST;
      irq     <= 1'b0;
    end else begin
      pready  <= apb_take;
      pslverr <= apb_take & ~mapped;
      if (apb_take && (!pwrite || !mapped)) begin
        if (a_stat)
          prdata <= {28'h0000000, status};
        else if (a_mask)
          prdata <= {28'h0000000, mask};
        else if (a_ctrl)
          prdata <= {31'h00000000, run};
        else if (a_state)
          prdata <= {16'h0000, s_ce, osc_stop_flag, periodic_irq_flag, wafg, dafg, periodic_select, sec};
        else
          prdata <= 32'h00000000;
      end
      status <= ev | (status & ~{4{stat_clr}});
      if (apb_done && pwrite && a_mask)
        mask <= pwdata[3:0];
      if (apb_done && pwrite && a_ctrl)
        run <= pwdata[0];
      irq <= |(status & mask);
    end
  end
endmodule // rtcha_top

// ### design/rtcha_consts.vh
// Constants of the real-time clock host-access block
`ifndef RTCHA_CONSTS_VH
`define RTCHA_CONSTS_VH
`define RTCHA_CLK_NS      10
`define RTCHA_SEC_NS      1000000000
`define RTCHA_SEC_CYCLES  (`RTCHA_SEC_NS / `RTCHA_CLK_NS)
`define RTCHA_MONTH_DAYS  8'd30
`define RTCHA_A_STATUS    8'h00
`define RTCHA_A_MASK      8'h04
`define RTCHA_A_CTRL      8'h08
`define RTCHA_A_STATE     8'h0C
`define RTCHA_EV_TICK     0
`define RTCHA_EV_PER      1
`define RTCHA_EV_ALARM    2
`define RTCHA_EV_ABORT    3
`define RTCHA_CTRL_RST    1'b1
`define RTCHA_S_SEC       4'h0
`define RTCHA_S_MIN       4'h1
`define RTCHA_S_HOUR      4'h2
`define RTCHA_S_WDAY      4'h3
`define RTCHA_S_DAY       4'h4
`define RTCHA_S_MON       4'h5
`define RTCHA_S_AWMIN     4'h8
`define RTCHA_S_AWHOUR    4'h9
`define RTCHA_S_AWDAYS    4'hA
`define RTCHA_S_ADMIN     4'hB
`define RTCHA_S_ADHOUR    4'hC
`define RTCHA_S_CTRL1     4'hE
`define RTCHA_S_CTRL2     4'hF
`define RTCHA_C1_WAE      7
`define RTCHA_C1_DAE      6
`define RTCHA_C1_OSC_STOP_FLAG     4
`define RTCHA_C2_PERIODIC_IRQ_FLAG     2
`define RTCHA_C2_WAFG     1
`define RTCHA_C2_DAFG     0
`define RTCHA_CMD_RD      3
`define RTCHA_BIT_HI      5'd11
`define RTCHA_BIT_LO      5'd15
`define RTCHA_BIT_END     5'd16
`define RTCHA_PS_OFF      3'h0
`define RTCHA_PS_LOW      3'h1
`define RTCHA_PS_2HZ      3'h2
`define RTCHA_PS_1HZ      3'h3
`define RTCHA_PS_SEC      3'h4
`define RTCHA_PS_MIN      3'h5
`define RTCHA_PS_HOUR     3'h6
`define RTCHA_PS_MON      3'h7
`endif

// ### design/rtcha_sync.v
// Three-stage input synchroniser with agreement filter
module rtcha_sync #(
  parameter WIDTH = 1
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= {WIDTH{1'b0}};
      s2 <= {WIDTH{1'b0}};
      s3 <= {WIDTH{1'b0}};
      q  <= {WIDTH{1'b0}};
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      // Take a change only once stages two and three agree
      q  <= (q & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
    end
  end
endmodule // rtcha_sync

// ### verification/rtcha_asserts.sv
// Port assertions for the RTC host-access block
module rtcha_asserts (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        ce,
  input logic        sio_oe,
  input logic        interrupt_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (pready && paddr > 8'h0C |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && paddr[1:0] == 2'h0 && paddr <= 8'h0C |-> !pslverr)
    else $error("mapped access refused");
  rdata_hold_a: assert property (!pready |-> $stable(prdata))
    else $error("prdata moved outside an answer");
  oe_release_a: assert property (!ce [*8] |-> !sio_oe)
    else $error("serial output driven with ce low");
  oe_start_a: assert property ($rose(sio_oe) |-> ce && $past(ce, 4))
    else $error("serial output started outside a frame");
  reset_quiet_a: assert property ($rose(presetn) |-> !pready && !pslverr && !sio_oe && !interrupt_oe)
    else $error("outputs active at reset release");
  cover property (pready && pslverr);
  cover property ($rose(sio_oe));
  cover property ($rose(interrupt_oe));
endmodule // rtcha_asserts

bind rtcha_top rtcha_asserts chk_u (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .ce, .sio_oe, .interrupt_oe);

// ### verification/rtcha_host.sv
// Host CPU model driving the three-wire serial link
module rtcha_host (
  input  logic       pclk,
  output logic       ce,
  output logic       sclk,
  output logic       sio_in,
  input  logic       sio_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd;
  initial begin
    ce = 1'b0;
    sclk = 1'b0;
    sio_in = 1'b0;
    rd = 8'h00;
  end
  // Frame of n bits MSB first; ce drops after the last one
  task automatic xfer(input logic [15:0] w, input int n);
    ce <= 1'b1;
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge pclk);
      sio_in <= w[15-i];
      repeat (8) @(posedge pclk);
      sclk <= 1'b1;
      if (i > 7)
        rd[15-i] <= sio_out;
      repeat (8) @(posedge pclk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge pclk);
    ce <= 1'b0;
    sio_in <= ~sio_in;
    repeat (16) @(posedge pclk);
  endtask
endmodule // rtcha_host

// ### verification/rtcha_top_tb.sv
// Testbench of the RTC host-access block
module rtcha_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        ce, sclk, sio_in, sio_out, sio_oe, osc_halt, backup_resume, interrupt_out_n, interrupt_oe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  int          n_errors, total_checks, cyc;

  rtcha_top #(.SEC_CYCLES(64)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .ce, .sclk, .sio_in, .sio_out, .sio_oe, .osc_halt, .backup_resume,
    .interrupt_out_n, .interrupt_oe);
  rtcha_host host_u (.pclk, .ce, .sclk, .sio_in, .sio_out);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic st();
    apb(1'b0, 8'h0C, 32'h0);
  endtask

  task automatic t_reset();
    repeat (10) @(posedge pclk);
    st();
    chk(rdat, 32'h0);
    apb(1'b1, 8'h04, 32'h8);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat, 32'h8);
    apb(1'b0, 8'h10, 32'h0);
    chk({rdat[30:0], err}, 32'h1);
  endtask

  task automatic t_osc();
    fork
      host_u.xfer(16'h0800, 16);
      begin
        repeat (60) @(posedge pclk);
        osc_halt <= 1'b1;
        repeat (20) @(posedge pclk);
        osc_halt <= 1'b0;
      end
    join
    st();
    chk(rdat[14], 1'b0);
    osc_halt <= 1'b1;
    repeat (20) @(posedge pclk);
    osc_halt <= 1'b0;
    repeat (10) @(posedge pclk);
    st();
    chk(rdat[14], 1'b1);
  endtask

  task automatic t_sec();
    host_u.xfer(16'h0005, 16);
    repeat (20) @(posedge pclk);
    st();
    chk(rdat[7:0], 8'h05);
    repeat (25) @(posedge pclk);
    st();
    chk(rdat[7:0], 8'h06);
  endtask

  task automatic t_abort();
    apb(1'b0, 8'h00, 32'h0);
    host_u.xfer(16'h802A, 16);
    host_u.xfer(16'h8800, 12);
    chk(irq, 1'b1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat[3], 1'b1);
    repeat (4) @(posedge pclk);
    chk(irq, 1'b0);
    host_u.xfer(16'h8800, 16);
    chk(host_u.rd, 8'h2A);
    host_u.xfer(16'h9000, 16);
    host_u.xfer(16'h9035, 12);
    host_u.xfer(16'h9800, 16);
    chk(host_u.rd, 8'h30);
  endtask

  task automatic t_level(input logic [2:0] code);
    apb(1'b1, 8'h08, 32'h0);
    host_u.xfer(16'h401E, 16);
    host_u.xfer(16'h2017, 16);
    host_u.xfer(16'h103B, 16);
    host_u.xfer(16'h003A, 16);
    host_u.xfer({13'h1C00, code}, 16);
    host_u.xfer(16'hF000, 16);
    apb(1'b1, 8'h08, 32'h1);
    repeat (80) @(posedge pclk);
    st();
    chk({rdat[13:8], rdat[7:0]}, {code == 3'h4, 2'b00, code, 8'h3B});
    chk(interrupt_oe, code == 3'h4);
    apb(1'b1, 8'h08, 32'h0);
    host_u.xfer(16'hF000, 16);
    apb(1'b1, 8'h08, 32'h1);
    repeat (80) @(posedge pclk);
    apb(1'b1, 8'h08, 32'h0);
    st();
    chk({rdat[13], rdat[7:0], interrupt_oe}, {1'b1, 8'h00, 1'b1});
    host_u.xfer(16'hF007, 16);
    st();
    chk(rdat[13], 1'b1);
    host_u.xfer(16'hF000, 16);
    st();
    chk({rdat[13], interrupt_oe}, 2'h0);
  endtask

  task automatic t_alarm();
    apb(1'b1, 8'h08, 32'h0);
    host_u.xfer(16'hE000, 16);
    host_u.xfer(16'hF000, 16);
    host_u.xfer(16'h003A, 16);
    host_u.xfer(16'h1005, 16);
    host_u.xfer(16'h2002, 16);
    host_u.xfer(16'hB006, 16);
    host_u.xfer(16'hC002, 16);
    host_u.xfer(16'hE040, 16);
    apb(1'b1, 8'h08, 32'h1);
    repeat (150) @(posedge pclk);
    apb(1'b1, 8'h08, 32'h0);
    st();
    chk({rdat[11], interrupt_oe}, 2'h3);
    host_u.xfer(16'hF000, 16);
    host_u.xfer(16'hE800, 16);
    chk(host_u.rd, 8'h40);
    st();
    chk({rdat[11], interrupt_oe}, 2'h0);
    host_u.xfer(16'hE000, 16);
    host_u.xfer(16'hA07F, 16);
    host_u.xfer(16'h8055, 16);
    host_u.xfer(16'h9055, 16);
    host_u.xfer(16'hB056, 16);
    host_u.xfer(16'hC056, 16);
    host_u.xfer(16'h003A, 16);
    host_u.xfer(16'hE0C0, 16);
    apb(1'b1, 8'h08, 32'h1);
    repeat (150) @(posedge pclk);
    apb(1'b1, 8'h08, 32'h0);
    st();
    chk({rdat[12:11], interrupt_oe}, 3'h0);
  endtask

  task automatic t_cold();
    presetn <= 1'b0;
    backup_resume <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    st();
    chk(rdat[14], 1'b1);
  endtask

  task automatic close_out();
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    {psel, penable, pwrite, osc_halt} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    backup_resume = 1'b1;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_osc();
    t_sec();
    t_abort();
    for (int c = 4; c < 8; c++)
      t_level(c[2:0]);
    t_alarm();
    t_cold();
    close_out();
  end
endmodule // rtcha_top_tb
